// ---- rtl/scd_pkg.sv ----
package scd_pkg;
  localparam logic [1:0] TYPE_FAST = 2'h0;
  localparam logic [1:0] TYPE_SREAD = 2'h1;
  localparam logic [1:0] TYPE_WRITE = 2'h2;
  localparam logic [1:0] TYPE_IREAD = 2'h3;
  localparam logic [3:0] FC_START = 4'ha;
  localparam logic [3:0] FC_STANDBY = 4'hb;
  localparam logic [3:0] FC_ADC_OFF = 4'hc;
  localparam logic [3:0] FC_FULL_OFF = 4'hd;
  localparam logic [3:0] FC_RESET = 4'he;
  localparam logic [1:0] MODE_CONVERT = 2'h3;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] CFG0_OFF = 8'h00;
  localparam logic [7:0] CFG0_RST = 8'h01;
  localparam logic [23:0] CONV_RST = 24'h000000;
  localparam logic [3:0] WR_ADDR_MIN = 4'h1;
  localparam logic [3:0] WR_ADDR_MAX = 4'hd;
  localparam logic [2:0] CNT_ADDR = 3'h1;
  localparam logic [2:0] CNT_LAST = 3'h7;
  localparam logic [2:0] FLAG_POR_ONLY = 3'h1;
  localparam int FLAG_DR = 2;
  localparam int FLAG_CRC = 1;
  localparam int FLAG_POR = 0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b10,
    ST_IGNORE = 2'b11
  } scd_state_t;
endpackage

// ---- rtl/scd_pins_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface scd_pins_if;
  logic cs_active;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic sdi;
  modport sync (output cs_active, cs_fall, cs_rise, sck_rise, sck_fall, sdi);
  modport core (input cs_active, cs_fall, cs_rise, sck_rise, sck_fall, sdi);
endinterface
`default_nettype wire

// ---- rtl/scd_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module scd_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  scd_pins_if.sync pins
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
    logic [1:0] last;
  } scd_sync_t;

  scd_sync_t s;
  scd_sync_t next_s;

  // two-stage capture, then edge finding on the second stage
  always_comb begin
    next_s = s;
    next_s.meta = {cs_n, sck, sdi};
    next_s.stable = s.meta;
    next_s.last = s.stable[2:1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.meta <= 3'h4;
      s.stable <= 3'h4;
      s.last <= 2'h2;
    end else begin
      s <= next_s;
    end
  end

  assign pins.cs_active = !s.stable[2];
  assign pins.cs_fall = s.last[1] && !s.stable[2];
  assign pins.cs_rise = !s.last[1] && s.stable[2];
  assign pins.sck_rise = !s.last[0] && s.stable[1];
  assign pins.sck_fall = s.last[0] && !s.stable[1];
  assign pins.sdi = s.stable[0];
endmodule
`default_nettype wire

// ---- rtl/scd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module scd_decoder #(
  parameter logic [1:0] DEVICE_ADDRESS = 2'h1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic fast_command_enable,
  input wire logic data_ready_event,
  input wire logic crc_error_event,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data_in,
  input wire logic [7:0] rd_byte,
  output logic sdo,
  output logic sdo_oe_n,
  output logic [1:0] adc_mode,
  output logic [7:0] first_configuration_register,
  output logic [23:0] conv_data,
  output logic [2:0] status_flags,
  output logic full_reset,
  output logic write_start,
  output logic read_start,
  output logic [3:0] access_addr,
  output logic [1:0] access_type
);
  typedef struct packed {
    scd_pkg::scd_state_t st;
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic [7:0] txbuf;
    logic [2:0] flags;
    logic [2:0] snap;
    logic sdo;
    logic sdo_oe_n;
    logic [1:0] adc_mode;
    logic [7:0] cfg0;
    logic [23:0] conv;
    logic full_reset;
    logic write_start;
    logic read_start;
    logic [3:0] addr;
    logic [1:0] ctype;
  } scd_core_t;

  scd_core_t s;
  scd_core_t next_s;
  scd_pins_if pins();

  logic addr_step;
  logic addr_ok;
  logic byte_end;
  logic [7:0] cmd_byte;
  logic fast_fire;
  logic [3:0] fcode;

  function automatic logic scd_writable(input logic [3:0] a);
    scd_writable = (a >= scd_pkg::WR_ADDR_MIN) && (a <= scd_pkg::WR_ADDR_MAX);
  endfunction

  function automatic logic scd_is_read(input logic [1:0] t);
    scd_is_read = t[0];
  endfunction

  scd_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sck(sck),
    .sdi(sdi),
    .pins(pins)
  );

  assign addr_step = (s.st == scd_pkg::ST_CMD) && pins.sck_rise &&
                     (s.cnt == scd_pkg::CNT_ADDR);
  assign addr_ok = ({s.shreg[0], pins.sdi} == DEVICE_ADDRESS);
  assign byte_end = (s.st == scd_pkg::ST_CMD) && pins.sck_rise &&
                    (s.cnt == scd_pkg::CNT_LAST);
  assign cmd_byte = {s.shreg[6:0], pins.sdi};
  assign fcode = cmd_byte[5:2];
  assign fast_fire = byte_end && !pins.cs_rise &&
                     (cmd_byte[1:0] == scd_pkg::TYPE_FAST) &&
                     fast_command_enable;

  always_comb begin
    next_s = s;
    next_s.full_reset = 1'b0;
    next_s.write_start = 1'b0;
    next_s.read_start = 1'b0;
    if (byte_end) begin
      next_s.flags = s.flags & ~s.snap;
    end
    // late events kept for next frame
    if (data_ready_event) begin
      next_s.flags[scd_pkg::FLAG_DR] = 1'b1;
    end
    if (crc_error_event) begin
      next_s.flags[scd_pkg::FLAG_CRC] = 1'b1;
    end
    if (conv_valid) begin
      next_s.conv = conv_data_in;
    end
    case (s.st)
      scd_pkg::ST_IDLE: begin
        if (pins.cs_fall) begin
          next_s.st = scd_pkg::ST_CMD;
          next_s.cnt = 3'h0;
          next_s.shreg = 8'h00;
          next_s.txbuf = 8'h00;
          next_s.snap = 3'h0;
          next_s.sdo = 1'b0;
          next_s.sdo_oe_n = 1'b0;
        end
      end
      scd_pkg::ST_CMD: begin
        if (pins.sck_rise) begin
          next_s.shreg = cmd_byte;
          next_s.cnt = s.cnt + 3'h1;
          if (addr_step) begin
            if (addr_ok) begin
              next_s.txbuf = {2'h0, DEVICE_ADDRESS, ~DEVICE_ADDRESS[0],
                              s.flags};
              next_s.snap = s.flags;
            end else begin
              next_s.st = scd_pkg::ST_IGNORE;
              next_s.sdo_oe_n = 1'b1;
            end
          end
          if (byte_end) begin
            next_s.ctype = cmd_byte[1:0];
            next_s.addr = fcode;
            next_s.st = scd_pkg::ST_DATA;
            case (cmd_byte[1:0])
              scd_pkg::TYPE_FAST: begin
                next_s.sdo_oe_n = 1'b1;
              end
              scd_pkg::TYPE_WRITE: begin
                next_s.sdo_oe_n = 1'b1;
                next_s.write_start = scd_writable(fcode);
              end
              default: begin
                next_s.read_start = 1'b1;
              end
            endcase
          end
        end
        if (pins.sck_fall) begin
          next_s.sdo = s.txbuf[3'h7 - s.cnt];
        end
      end
      scd_pkg::ST_DATA: begin
        if (scd_is_read(s.ctype)) begin
          if (pins.sck_rise) begin
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == scd_pkg::CNT_LAST) begin
              next_s.read_start = 1'b1;
              if (s.ctype == scd_pkg::TYPE_IREAD) begin
                next_s.addr = s.addr + 4'h1;
              end
            end
          end
          if (pins.sck_fall) begin
            if (s.cnt == 3'h0) begin
              next_s.txbuf = rd_byte;
              next_s.sdo = rd_byte[7];
            end else begin
              next_s.sdo = s.txbuf[3'h7 - s.cnt];
            end
          end
        end
      end
      scd_pkg::ST_IGNORE: begin
        next_s.sdo_oe_n = 1'b1;
      end
      default: begin
        next_s.st = scd_pkg::ST_IDLE;
      end
    endcase
    // fast command acts at bit eight
    if (fast_fire) begin
      case (fcode)
        scd_pkg::FC_START: next_s.adc_mode = scd_pkg::MODE_CONVERT;
        scd_pkg::FC_STANDBY: next_s.adc_mode = scd_pkg::MODE_STANDBY;
        scd_pkg::FC_ADC_OFF: next_s.adc_mode = scd_pkg::MODE_OFF;
        scd_pkg::FC_FULL_OFF: next_s.cfg0 = scd_pkg::CFG0_OFF;
        scd_pkg::FC_RESET: begin
          next_s.adc_mode = scd_pkg::MODE_RST;
          next_s.cfg0 = scd_pkg::CFG0_RST;
          next_s.conv = scd_pkg::CONV_RST;
          next_s.flags = scd_pkg::FLAG_POR_ONLY;
          next_s.full_reset = 1'b1;
        end
        default: begin
          next_s.full_reset = 1'b0;
        end
      endcase
    end
    if (pins.cs_rise) begin
      next_s.st = scd_pkg::ST_IDLE;
      next_s.sdo_oe_n = 1'b1;
      next_s.sdo = 1'b0;
      next_s.cnt = 3'h0;
      next_s.write_start = 1'b0;
      next_s.read_start = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= scd_pkg::ST_IDLE;
      s.sdo_oe_n <= 1'b1;
      s.adc_mode <= scd_pkg::MODE_RST;
      s.cfg0 <= scd_pkg::CFG0_RST;
      s.conv <= scd_pkg::CONV_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sdo = s.sdo;
  assign sdo_oe_n = s.sdo_oe_n;
  assign adc_mode = s.adc_mode;
  assign first_configuration_register = s.cfg0;
  assign conv_data = s.conv;
  assign status_flags = s.flags;
  assign full_reset = s.full_reset;
  assign write_start = s.write_start;
  assign read_start = s.read_start;
  assign access_addr = s.addr;
  assign access_type = s.ctype;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_fire(logic [3:0] code);
    fast_fire && fcode == code;
  endsequence

  a_status_top_zero: assert property (
    (s.st == scd_pkg::ST_CMD && s.cnt < 3'h2 && !s.sdo_oe_n) |-> !s.sdo)
    else $error("status msbs not zero");
  a_mismatch_release: assert property (
    (addr_step && !addr_ok && !pins.cs_rise) |=>
      s.sdo_oe_n [*3])
    else $error("output driven after mismatch");
  a_select_rise_idle: assert property (
    pins.cs_rise |=> (s.st == scd_pkg::ST_IDLE && s.sdo_oe_n))
    else $error("frame not abandoned");
  a_fast_start: assert property (
    seq_fire(scd_pkg::FC_START) |=> adc_mode == 2'h3)
    else $error("start code failed");
  a_fast_standby: assert property (
    seq_fire(scd_pkg::FC_STANDBY) |=> adc_mode == 2'h2)
    else $error("standby code failed");
  a_fast_shutdown: assert property (
    seq_fire(scd_pkg::FC_ADC_OFF) |=> adc_mode == 2'h0)
    else $error("shutdown code failed");
  a_full_shutdown: assert property (
    seq_fire(scd_pkg::FC_FULL_OFF) |=> first_configuration_register == 8'h00)
    else $error("full shutdown failed");
  a_full_reset: assert property (
    seq_fire(scd_pkg::FC_RESET) |=> (full_reset && conv_data == 24'h0 &&
      first_configuration_register == scd_pkg::CFG0_RST))
    else $error("full reset incomplete");
  a_por_flag_set: assert property (
    seq_fire(scd_pkg::FC_RESET) |=> status_flags[0] ##1 !full_reset)
    else $error("power-on flag not set");
  a_fast_disabled: assert property (
    (byte_end && !fast_command_enable) |=>
      ($stable(adc_mode) && $stable(first_configuration_register)))
    else $error("fast command ran while disabled");
  a_ignored_codes: assert property (
    (fast_fire && (!fcode[3] || fcode[3:1] == 3'h4 || fcode == 4'hf)) |=>
      ($stable(adc_mode) && !full_reset))
    else $error("ignored code had effect");
  a_ignore_frame: assert property (
    (s.st == scd_pkg::ST_IGNORE) |=>
      ($stable(adc_mode) && $stable(first_configuration_register) &&
       !write_start && !read_start))
    else $error("mismatched frame changed state");
  a_ack_bits: assert property (
    (addr_step && addr_ok && !pins.cs_rise) |=>
      s.txbuf[5:3] == {DEVICE_ADDRESS, ~DEVICE_ADDRESS[0]})
    else $error("acknowledge bits wrong");
  a_readonly_write: assert property (
    (byte_end && cmd_byte[1:0] == scd_pkg::TYPE_WRITE &&
     !scd_writable(fcode)) |=> !write_start)
    else $error("write to read-only started");

  sequence seq_byte_done;
    byte_end && !pins.cs_rise;
  endsequence

  a_select_fall_low: assert property (
    (s.st == scd_pkg::ST_IDLE && pins.cs_fall) |=>
      (!s.sdo_oe_n && !s.sdo))
    else $error("output not low at select fall");
  a_idle_released: assert property (
    (!pins.cs_active && !pins.cs_rise) |-> s.sdo_oe_n)
    else $error("output driven while deselected");
  a_write_started: assert property (
    (seq_byte_done ##0 (cmd_byte[1:0] == scd_pkg::TYPE_WRITE &&
      scd_writable(fcode))) |=> write_start)
    else $error("write to writable address not started");
  a_read_started: assert property (
    (seq_byte_done ##0 cmd_byte[0]) |=> read_start)
    else $error("read not started");
  a_release_after_status: assert property (
    (byte_end && !cmd_byte[0]) |=> s.sdo_oe_n)
    else $error("output driven after status");
  a_status_clear: assert property (
    (byte_end && s.snap[scd_pkg::FLAG_DR] && !data_ready_event) |=>
      !status_flags[scd_pkg::FLAG_DR])
    else $error("sent flag not cleared");
  a_event_kept: assert property (
    (data_ready_event && !fast_fire) |=> status_flags[scd_pkg::FLAG_DR])
    else $error("late event lost");
  a_conv_kept: assert property (
    (!conv_valid && !(fast_fire && fcode == scd_pkg::FC_RESET)) |=>
      $stable(conv_data))
    else $error("conversion data changed");
  a_type_held: assert property (
    (s.st == scd_pkg::ST_DATA) |=> $stable(access_type))
    else $error("command type changed in frame");
endmodule
`default_nettype wire

// ---- verif/scd_spi_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module scd_spi_master (
  input wire logic clk,
  input wire logic sdo_pin,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  task automatic xfer(input logic [7:0] cmd, input int nbits, input int half,
      output logic [15:0] rx, output logic tail);
    int i;
    rx = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      sdi = (i < 8) ? cmd[7 - i] : ~sdi;
      repeat (half) @(negedge clk);
      rx = {rx[14:0], sdo_pin};
      sck = 1'b1;
      repeat (half) @(negedge clk);
      sck = 1'b0;
    end
    repeat (half) @(negedge clk);
    tail = sdo_pin;
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (half) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- verif/spi_command_status_decoder_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_command_status_decoder_test;
  localparam logic [1:0] DEV = 2'h2;
  logic clk, rst_n, fast_command_enable, data_ready_event, crc_error_event;
  logic conv_valid, sdo, sdo_oe_n, full_reset, write_start, read_start;
  logic [23:0] conv_data_in, conv_data, m_conv;
  logic [7:0] rd_byte, cfg, m_cfg, cmd;
  logic [1:0] adc_mode, access_type, m_mode;
  logic [2:0] status_flags, m_flags;
  logic [3:0] access_addr;
  wire logic cs_n, sck, sdi, sdo_pin;
  int bad_count, cmp_count, wr_cnt, rd_cnt, rst_cnt, i;
  int unsigned seed;

  assign sdo_pin = sdo_oe_n ? 1'bz : sdo;

  scd_decoder #(.DEVICE_ADDRESS(DEV)) i_scd_decoder (.clk(clk),
    .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .fast_command_enable(fast_command_enable),
    .data_ready_event(data_ready_event), .crc_error_event(crc_error_event),
    .conv_valid(conv_valid), .conv_data_in(conv_data_in),
    .rd_byte(rd_byte), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .adc_mode(adc_mode),
    .first_configuration_register(cfg), .conv_data(conv_data),
    .status_flags(status_flags), .full_reset(full_reset),
    .write_start(write_start), .read_start(read_start),
    .access_addr(access_addr), .access_type(access_type));

  scd_spi_master i_scd_spi_master (.clk(clk), .sdo_pin(sdo_pin),
    .cs_n(cs_n), .sck(sck), .sdi(sdi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (write_start === 1'b1) wr_cnt++;
    if (read_start === 1'b1) rd_cnt++;
    if (full_reset === 1'b1) rst_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_status(input logic [7:0] c,
      input logic [2:0] fl);
    if (c[7:6] != DEV) return {2'b00, 6'bzzzzzz};
    return {2'b00, DEV, ~DEV[0], fl};
  endfunction

  function automatic int exp_writes(input logic [7:0] c);
    return (c[1:0] == scd_pkg::TYPE_WRITE && c[5:2] >= scd_pkg::WR_ADDR_MIN
      && c[5:2] <= scd_pkg::WR_ADDR_MAX) ? 1 : 0;
  endfunction

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    m_mode = scd_pkg::MODE_RST;
    m_cfg = scd_pkg::CFG0_RST;
    m_conv = scd_pkg::CONV_RST;
    m_flags = 3'h0;
    repeat (3) @(negedge clk);
  endtask

  task automatic fire_events(input logic dr, input logic crc, input logic cv);
    @(negedge clk);
    data_ready_event = dr;
    crc_error_event = crc;
    conv_valid = cv;
    conv_data_in = 24'($urandom());
    if (dr) m_flags[scd_pkg::FLAG_DR] = 1'b1;
    if (crc) m_flags[scd_pkg::FLAG_CRC] = 1'b1;
    if (cv) m_conv = conv_data_in;
    @(negedge clk);
    data_ready_event = 1'b0;
    crc_error_event = 1'b0;
    conv_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic do_frame(input logic [7:0] c, input int nb, input int half);
    logic [15:0] rx;
    logic tail, match;
    int nbits, exp_rst;
    match = (c[7:6] == DEV);
    nbits = (nb < 0) ? 5 : 8 * (1 + nb);
    exp_rst = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    rst_cnt = 0;
    i_scd_spi_master.xfer(c, nbits, half, rx, tail);
    if (nb >= 0) begin
      check(nb == 0 ? rx[7:0] : rx[15:8], exp_status(c, m_flags));
      if (match) begin
        m_flags = 3'h0;
        if (c[1:0] == scd_pkg::TYPE_FAST && fast_command_enable) begin
          case (c[5:2])
            scd_pkg::FC_START: m_mode = scd_pkg::MODE_CONVERT;
            scd_pkg::FC_STANDBY: m_mode = scd_pkg::MODE_STANDBY;
            scd_pkg::FC_ADC_OFF: m_mode = scd_pkg::MODE_OFF;
            scd_pkg::FC_FULL_OFF: m_cfg = scd_pkg::CFG0_OFF;
            scd_pkg::FC_RESET: begin
              m_mode = scd_pkg::MODE_RST;
              m_cfg = scd_pkg::CFG0_RST;
              m_conv = scd_pkg::CONV_RST;
              m_flags = scd_pkg::FLAG_POR_ONLY;
              exp_rst = 1;
            end
            default: ;
          endcase
        end
        check(access_type, c[1:0]);
        check(wr_cnt, exp_writes(c));
        check(rd_cnt, c[0] ? 1 + nb : 0);
        check(rst_cnt, exp_rst);
        if (c[0] && nb > 0) begin
          check(rx[7:0], rd_byte);
          check(access_addr, 4'(c[5:2] + (c[1] ? 4'(nb) : 4'h0)));
        end
      end else begin
        check(wr_cnt + rd_cnt + rst_cnt, 0);
      end
      if (!match || !c[0]) check(tail, 1'bz);
    end
    check(adc_mode, m_mode);
    check(cfg, m_cfg);
    check(conv_data, m_conv);
    check(status_flags, m_flags);
  endtask

  initial begin
    #1000000;
    bad_count++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    fast_command_enable = 1'b1;
    data_ready_event = 1'b0;
    crc_error_event = 1'b0;
    conv_valid = 1'b0;
    conv_data_in = 24'h000000;
    rd_byte = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    seed = $urandom(68);
    do_reset();
    check(status_flags, 3'h0);
    fire_events(1'b1, 1'b1, 1'b1);
    for (i = 0; i < 16; i++) begin
      do_frame({DEV, 4'(i), scd_pkg::TYPE_FAST}, 0, 8);
      if (i == 12) fire_events(1'b0, 1'b0, 1'b1);
    end
    fast_command_enable = 1'b0;
    do_frame({DEV, scd_pkg::FC_START, scd_pkg::TYPE_FAST}, 0, 8);
    fast_command_enable = 1'b1;
    fire_events(1'b1, 1'b0, 1'b0);
    do_frame({~DEV, scd_pkg::FC_START, scd_pkg::TYPE_FAST}, 1, 8);
    do_frame({DEV, scd_pkg::FC_STANDBY, scd_pkg::TYPE_FAST}, -1, 8);
    for (i = 0; i < 16; i++) begin
      do_frame({DEV, 4'(i), scd_pkg::TYPE_WRITE}, 0, 8);
    end
    rd_byte = 8'ha5;
    do_frame({DEV, 4'hf, scd_pkg::TYPE_IREAD}, 1, 12);
    do_frame({DEV, 4'h3, scd_pkg::TYPE_SREAD}, 1, 8);
    for (i = 0; i < 60; i++) begin
      fire_events(1'($urandom()), 1'($urandom()), 1'($urandom()));
      rd_byte = 8'($urandom());
      fast_command_enable = ($urandom() % 4 != 0);
      cmd = 8'($urandom());
      if ($urandom() % 4 != 0) cmd[7:6] = DEV;
      do_frame(cmd, cmd[0] ? int'($urandom() % 2) : 0, 8 + $urandom() % 6);
    end
    do_reset();
    check(status_flags, 3'h0);
    do_frame({DEV, scd_pkg::FC_START, scd_pkg::TYPE_FAST}, 0, 8);
    final_report();
  end
endmodule
`default_nettype wire
